// ### hdl/fwg_params.svh
`ifndef FWG_PARAMS_SVH
`define FWG_PARAMS_SVH

// register byte offsets on the cpu-side apb port
`define FWG_OFF_CTRL       12'h000
`define FWG_OFF_KEY        12'h004
`define FWG_OFF_CMD        12'h008
`define FWG_OFF_ADDR       12'h00C
`define FWG_OFF_DATA       12'h010
`define FWG_OFF_STATUS     12'h014

// control field positions
`define FWG_BIT_WE         0
`define FWG_BIT_EE         1
`define FWG_BIT_SP         2
`define FWG_CTRL_MASK      8'h07
`define FWG_CTRL_RESET     8'h00

// unlock keys
`define FWG_KEY_FIRST      8'hA5
`define FWG_KEY_SECOND     8'hF1

// lock state encodings as read back
`define FWG_LK_LOCKED      2'h0
`define FWG_LK_FIRST       2'h1
`define FWG_LK_OPEN        2'h2
`define FWG_LK_DEAD        2'h3

// memory geometry
`define FWG_MAIN_WORDS     1024
`define FWG_SCR_WORDS      1024
`define FWG_PAGE_BITS      7
`define FWG_ERASED         8'hFF

// link command codes
`define FWG_OP_NONE        2'h0
`define FWG_OP_WRCTRL      2'h1
`define FWG_OP_WRKEY       2'h2
`define FWG_OP_MEM         2'h3

`endif

// ### hdl/fwg_pkg.sv
package fwg_pkg;
	typedef enum logic [1:0] {
		FWG_LOCKED = 2'b00,
		FWG_FIRST  = 2'b01,
		FWG_OPEN   = 2'b10,
		FWG_DEAD   = 2'b11
	} fwg_lock_t;

	typedef enum logic [1:0] {
		FWG_MEM_RD  = 2'b00,
		FWG_MEM_WR  = 2'b01,
		FWG_MEM_RSV = 2'b10,
		FWG_MEM_NOP = 2'b11
	} fwg_mem_t;
endpackage

// ### hdl/fwg_link_if.sv
`timescale 1ns/1ps
interface fwg_link_if;
	logic                req;
	logic [1:0]          op;
	logic                mem_write;
	logic [15:0]         addr;
	logic [7:0]          wdata;
	logic                ack;
	logic [7:0]          rdata;
	logic [7:0]          ctrl_rd;
	logic [7:0]          key_rd;

	modport guard (
		input  req, op, mem_write, addr, wdata,
		output ack, rdata, ctrl_rd, key_rd
	);
	modport cpu (
		output req, op, mem_write, addr, wdata,
		input  ack, rdata, ctrl_rd, key_rd
	);
endinterface

// ### hdl/fwg_guard.sv
`timescale 1ns/1ps
`include "fwg_params.svh"

// How it works
// - control bits 7..3 read zero, writes ignored
// - scratchpad select routes reads and writes there
// - select clear uses main program sector
// - software stays inside scratchpad range when selected
// - erase plus write enable erases whole page
// - write enable alone programs one byte
// - clear enable bits block writes and erases
// - software erases before programming a byte
// - keys 0xA5 then 0xF1 unlock flash
// - one operation re-arms the lock
// - bad key or locked attempt locks until reset
// - key write after unlock locks until reset
// - lock register reads lock state low bits
module fwg_guard (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// cpu link
	fwg_link_if.guard         link,
	// status for observation
	output logic [1:0]        lock_state,
	output logic              write_done,
	output logic              erase_done
);
	logic [7:0]         main_mem [0:`FWG_MAIN_WORDS-1];
	logic [7:0]         scr_mem  [0:`FWG_SCR_WORDS-1];
	logic [2:0]         ctrl;
	logic [2:0]         next_ctrl;
	fwg_pkg::fwg_lock_t lock;
	fwg_pkg::fwg_lock_t next_lock;
	logic               ack;
	logic [7:0]         rdata;
	logic [7:0]         next_rdata;
	logic               do_write;
	logic               do_erase;
	logic               sp;
	logic [9:0]         widx;
	logic               take;
	logic               next_ack;
	logic               next_write_done;
	logic               next_erase_done;
	logic               wr_main;
	logic               wr_scr;
	logic               er_main;
	logic               er_scr;

	function automatic logic in_page(input logic [9:0] a, input logic [9:0] b);
		in_page = a[9:`FWG_PAGE_BITS] == b[9:`FWG_PAGE_BITS];
	endfunction

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	// a request is taken once: ack blocks the cycle after it
	assign take = link.req && !ack;
	// upper address bits dropped: both sectors are 1024 bytes
	assign widx = link.addr[9:0];
	assign sp   = ctrl[`FWG_BIT_SP];

	// ----------------------------------------
	// control and lock
	// ----------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_lock = lock;
		do_write  = 1'b0;
		do_erase  = 1'b0;
		if (take) begin
			case (link.op)
				`FWG_OP_WRCTRL: begin
					next_ctrl = link.wdata[2:0];
				end
				`FWG_OP_WRKEY: begin
					case (lock)
						fwg_pkg::FWG_LOCKED: begin
							if (link.wdata == `FWG_KEY_FIRST) begin
								next_lock = fwg_pkg::FWG_FIRST;
							end else begin
								next_lock = fwg_pkg::FWG_DEAD;
							end
						end
						fwg_pkg::FWG_FIRST: begin
							if (link.wdata == `FWG_KEY_SECOND) begin
								next_lock = fwg_pkg::FWG_OPEN;
							end else begin
								next_lock = fwg_pkg::FWG_DEAD;
							end
						end
						fwg_pkg::FWG_OPEN: begin
							// keying again after unlock is a bad sequence
							next_lock = fwg_pkg::FWG_DEAD;
						end
						default: begin
							// only presetn leaves the dead state
							next_lock = fwg_pkg::FWG_DEAD;
						end
					endcase
				end
				`FWG_OP_MEM: begin
					// write enable clear is no flash access, so the lock stays
					if (link.mem_write && ctrl[`FWG_BIT_WE]) begin
						if (lock == fwg_pkg::FWG_OPEN) begin
							do_erase  = ctrl[`FWG_BIT_EE];
							do_write  = !ctrl[`FWG_BIT_EE];
							next_lock = fwg_pkg::FWG_LOCKED;
						end else begin
							next_lock = fwg_pkg::FWG_DEAD;
						end
					end
				end
				default: begin
					next_lock = lock;
				end
			endcase
		end
	end

	// registers only; every decision is made in the block above
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 3'h0;
			lock <= fwg_pkg::FWG_LOCKED;
		end else begin
			ctrl <= next_ctrl;
			lock <= next_lock;
		end
	end

	// ----------------------------------------
	// flash arrays
	// ----------------------------------------
	// sector steering for the one operation let through
	always_comb begin
		wr_main = do_write && !sp;
		wr_scr  = do_write && sp;
		er_main = do_erase && !sp;
		er_scr  = do_erase && sp;
	end

	// arrays have no reset; erase fills with the erased value
	// write and erase never share a cycle, so their order is moot
	always_ff @(posedge pclk) begin
		for (int i = 0; i < `FWG_MAIN_WORDS; i++) begin
			if (er_main && in_page(10'(i), widx)) begin
				main_mem[i] <= `FWG_ERASED;
			end
		end
		if (wr_main) begin
			main_mem[widx] <= link.wdata;
		end
	end

	always_ff @(posedge pclk) begin
		for (int i = 0; i < `FWG_SCR_WORDS; i++) begin
			if (er_scr && in_page(10'(i), widx)) begin
				scr_mem[i] <= `FWG_ERASED;
			end
		end
		if (wr_scr) begin
			scr_mem[widx] <= link.wdata;
		end
	end

	// ----------------------------------------
	// answer
	// ----------------------------------------
	always_comb begin
		next_ack        = take;
		next_write_done = do_write;
		next_erase_done = do_erase;
		next_rdata      = rdata;
		if (take && link.op == `FWG_OP_MEM && !link.mem_write) begin
			next_rdata = sp ? scr_mem[widx] : main_mem[widx];
		end
	end

	// ack is a one-cycle pulse, so a req still held after it is taken again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack        <= 1'b0;
			rdata      <= 8'h00;
			write_done <= 1'b0;
			erase_done <= 1'b0;
		end else begin
			ack        <= next_ack;
			rdata      <= next_rdata;
			write_done <= next_write_done;
			erase_done <= next_erase_done;
		end
	end

	// ----------------------------------------
	// readback
	// ----------------------------------------
	// pad bits are constants, so software never sees stale bits
	assign link.ack     = ack;
	assign link.rdata   = rdata;
	assign link.ctrl_rd = {5'h00, ctrl};
	assign link.key_rd  = {6'h00, lock};
	assign lock_state   = lock;
endmodule

// ### hdl/fwg_cpu.sv
`timescale 1ns/1ps
`include "fwg_params.svh"

// cpu end: apb writes to the ctrl, key and cmd registers turn into one link request each
module fwg_cpu (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// guard link
	fwg_link_if.cpu           link
);
	logic        busy;
	logic        next_busy;
	logic [1:0]  op;
	logic [1:0]  next_op;
	logic        mw;
	logic        next_mw;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic [7:0]  wd;
	logic [7:0]  next_wd;
	logic [7:0]  rd;
	logic [7:0]  next_rd;
	logic        access;
	logic        launch;
	logic [7:0]  dat;
	logic [7:0]  next_dat;

	assign access = psel && penable;
	assign launch = access && pwrite
		&& (paddr == `FWG_OFF_CTRL || paddr == `FWG_OFF_KEY || paddr == `FWG_OFF_CMD);

	// ----------------------------------------
	// register side
	// ----------------------------------------
	// cmd write launches a link op; apb waits for the guard's ack
	always_comb begin
		next_busy = busy;
		next_op   = op;
		next_mw   = mw;
		next_addr = addr;
		next_wd   = wd;
		next_rd   = rd;
		next_dat  = dat;
		if (busy) begin
			if (link.ack) begin
				next_busy = 1'b0;
				next_rd   = link.rdata;
			end
		end else if (access && pwrite) begin
			case (paddr)
				`FWG_OFF_CTRL: begin
					next_busy = 1'b1;
					next_op   = `FWG_OP_WRCTRL;
					next_wd   = pwdata[7:0] & `FWG_CTRL_MASK;
				end
				`FWG_OFF_KEY: begin
					next_busy = 1'b1;
					next_op   = `FWG_OP_WRKEY;
					next_wd   = pwdata[7:0];
				end
				`FWG_OFF_ADDR: begin
					next_addr = pwdata[15:0];
				end
				`FWG_OFF_DATA: begin
					next_dat = pwdata[7:0];
				end
				`FWG_OFF_CMD: begin
					next_busy = 1'b1;
					next_op   = `FWG_OP_MEM;
					next_mw   = pwdata[0];
				end
				default: begin
					next_busy = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			op   <= `FWG_OP_NONE;
			mw   <= 1'b0;
			addr <= 16'h0000;
			wd   <= 8'h00;
			rd   <= 8'h00;
			dat  <= 8'h00;
		end else begin
			busy <= next_busy;
			op   <= next_op;
			mw   <= next_mw;
			addr <= next_addr;
			wd   <= next_wd;
			rd   <= next_rd;
			dat  <= next_dat;
		end
	end

	// a launching write waits for the guard's ack pulse and is ready with it,
	// so the same access can never launch a second op
	assign pready = busy ? link.ack : !launch;

	always_comb begin
		pslverr = 1'b0;
		prdata  = 32'h00000000;
		case (paddr)
			`FWG_OFF_CTRL:   prdata = {24'h000000, link.ctrl_rd};
			`FWG_OFF_KEY:    prdata = {24'h000000, link.key_rd};
			`FWG_OFF_ADDR:   prdata = {16'h0000, addr};
			`FWG_OFF_DATA:   prdata = {24'h000000, rd};
			`FWG_OFF_STATUS: prdata = {31'h00000000, busy};
			`FWG_OFF_CMD:    prdata = {30'h00000000, op};
			default:         pslverr = access;
		endcase
	end

	assign link.req       = busy;
	assign link.op        = op;
	assign link.mem_write = mw;
	assign link.addr      = addr;
	// the data byte survives control and key writes made after it
	assign link.wdata     = (op == `FWG_OP_MEM) ? dat : wd;
endmodule

// ### tb/fwg_checker.sv
`timescale 1ns/1ps
module fwg_checker (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// link
	input wire logic       req,
	input wire logic [1:0] op,
	input wire logic       mem_write,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] ctrl_rd,
	input wire logic [7:0] key_rd
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic       tk;
	logic [1:0] ks;
	assign tk = req && !ack;
	assign ks = key_rd[1:0];
	a_pad_zero:
	assert property (ctrl_rd[7:3] == 5'h00 && key_rd[7:2] == 6'h00) else $error("pad bits set");
	a_reset_clear:
	assert property ($rose(presetn) |-> ctrl_rd == 8'h00 && ks == 2'h0) else $error("reset values");
	a_ack_pulse:
	assert property (tk |=> ack ##1 !ack) else $error("ack timing");
	a_ctrl_mask:
	assert property (tk && op == 2'h1 |=> ctrl_rd == ($past(wdata) & 8'h07)) else $error("ctrl write");
	a_key_first:
	assert property (tk && op == 2'h2 && ks == 2'h0 |=> ks == ($past(wdata) == 8'hA5 ? 2'h1 : 2'h3))
		else $error("first key");
	a_key_second:
	assert property (tk && op == 2'h2 && ks == 2'h1 |=> ks == ($past(wdata) == 8'hF1 ? 2'h2 : 2'h3))
		else $error("second key");
	a_dead_holds:
	assert property (ks == 2'h3 |=> ks == 2'h3) else $error("dead lock left");
	a_op_rearm:
	assert property (tk && op == 2'h3 && mem_write && ctrl_rd[0] |=> ks == ($past(ks) == 2'h2 ? 2'h0 : 2'h3))
		else $error("lock after op");
	a_idle_stable:
	assert property (!tk |=> $stable(ks) && $stable(ctrl_rd)) else $error("state moved idle");
endmodule

// ### tb/tb_fwg_guard.sv
`timescale 1ns/1ps
module tb_fwg_guard;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        er;
	int          failures = 0;
	int          total_checks = 0;
	fwg_link_if link ();
	fwg_cpu fwg_cpu_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.cpu));
	fwg_guard fwg_guard_inst (.pclk(pclk), .presetn(presetn), .link(link.guard), .lock_state(),
		.write_done(), .erase_done());
	fwg_checker fwg_checker_inst (.pclk(pclk), .presetn(presetn), .req(link.req), .op(link.op),
		.mem_write(link.mem_write), .wdata(link.wdata), .ack(link.ack), .ctrl_rd(link.ctrl_rd), .key_rd(link.key_rd));
	always #50 pclk = ~pclk;
	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready, read data and error are taken at the completing rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// a hung access counts as a mismatch; the run goes on to the verdict
		if (n >= 40) begin
			chk("pready", 1, 0);
		end
		@(posedge pclk);
	endtask
	task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	task automatic rmem(input logic [7:0] c, input logic [9:0] a, input logic [7:0] exp);
		apb(1'b1, 12'h000, {24'h0, c});
		apb(1'b1, 12'h00C, {22'h0, a});
		apb(1'b1, 12'h008, 32'h0);
		rreg(12'h010, {24'h0, exp}, "mem");
	endtask
	// ctrl, both keys, then one write command
	task automatic fop(input logic [7:0] c, input logic [9:0] a, input logic [7:0] d, input logic [7:0] k2);
		apb(1'b1, 12'h00C, {22'h0, a});
		apb(1'b1, 12'h010, {24'h0, d});
		apb(1'b1, 12'h000, {24'h0, c});
		apb(1'b1, 12'h004, 32'hA5);
		rreg(12'h004, 1, "key first");
		apb(1'b1, 12'h004, {24'h0, k2});
		rreg(12'h004, (k2 == 8'hF1) ? 2 : 3, "key second");
		apb(1'b1, 12'h008, 32'h1);
		if (c[0]) begin
			rreg(12'h004, (k2 == 8'hF1) ? 0 : 3, "key after op");
		end
	endtask
	task automatic rst();
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rreg(12'h000, 0, "ctrl reset");
		rreg(12'h004, 0, "key reset");
		apb(1'b1, 12'h000, 32'hFF);
		rreg(12'h000, 32'h07, "ctrl pad");
		apb(1'b0, 12'h018, 32'h0);
		chk("slverr", 1, er);
		fop(8'h03, 10'h080, 8'h00, 8'hF1);
		rmem(8'h00, 10'h085, 8'hFF);
		rmem(8'h00, 10'h0FF, 8'hFF);
		fop(8'h01, 10'h085, 8'h3C, 8'hF1);
		rmem(8'h00, 10'h085, 8'h3C);
		rmem(8'h00, 10'h086, 8'hFF);
		fop(8'h07, 10'h080, 8'h00, 8'hF1);
		fop(8'h05, 10'h085, 8'h5A, 8'hF1);
		rmem(8'h04, 10'h085, 8'h5A);
		rmem(8'h00, 10'h085, 8'h3C);
		fop(8'h00, 10'h085, 8'h11, 8'hF1);
		apb(1'b1, 12'h000, 32'h2);
		apb(1'b1, 12'h008, 32'h1);
		rmem(8'h00, 10'h085, 8'h3C);
		rst();
		apb(1'b1, 12'h004, 32'h12);
		rreg(12'h004, 3, "key deliberate");
		rst();
		fop(8'h01, 10'h085, 8'h00, 8'h00);
		rmem(8'h00, 10'h085, 8'h3C);
		rst();
		apb(1'b1, 12'h00C, 32'h85);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h008, 32'h1);
		rreg(12'h004, 3, "key locked op");
		rmem(8'h00, 10'h085, 8'h3C);
		summarize();
	end
endmodule
